//--- verilog/dmhp_serial_port.v
// Purpose: two-wire / three-wire serial host port writing and reading registers
// Assumes: bus pins are asynchronous; register storage sits outside this block
// Notes:   bus pins are oversampled by clock; bit progress follows bus clock edges, frames follow start, stop and select
//          a stretched host clock is harmless: there is no timeout anywhere
//          pin changes closer than two clocks to a clock edge may be misread
//
// Behaviour
// - mode pin low selects two-wire protocol, high selects three-wire protocol.
// - accesses accepted anytime; bit sequencing driven only by host bus clock edges.
// - two-wire: data change while clock high is a start or stop.
// - falling data with clock high is start; begins a new transfer.
// - rising data with clock high is stop; interface returns to idle.
// - after eight bits the sender releases; receiver pulls low in ninth clock.
// - seven-bit address msb first, then direction bit: 0 write, 1 read.
// - matching address acknowledged, then sub-address 00h..0Fh and data bytes.
// - read: write address, sub 80h/81h, repeated start, read address, eight bits out.
// - three-wire transfers only while select is low; ignored while high.
// - three-wire stream has no slave address; starts with the sub-address.
// - three-wire write: sub 00h..0Fh then data msb first, ended by select high.
// - three-wire read: sub 80h/81h then eight bits out msb first.
// - data pin only ever pulled low; high level comes from the pull-up.
`timescale 1ns/10ps
`default_nettype none
`include "dmhp_consts.vh"

module dmhp_serial_port #(
  // slave address value is arbitrary
  parameter [6:0] SLAVE_ADDR = 7'h2A
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        protocolSelectPin,
  input  wire        selectLineN,
  input  wire        serialClockLine,
  input  wire        serialDataLineIn,
  output wire        serialDataLineOut,
  output wire        serialDataLineOe,
  output wire        regWrStrobe,
  output wire [3:0]  regWrAddr,
  output wire [15:0] regWrData,
  output wire        regRdSel,
  output wire        regRdStrobe,
  input  wire [7:0]  regRdData,
  output wire        busActive
);

  // ============================================================
  // states
  localparam [2:0] ST_IDLE   = 3'b000;
  localparam [2:0] ST_ADDR   = 3'b001;
  localparam [2:0] ST_SUB    = 3'b010;
  localparam [2:0] ST_DATA   = 3'b011;
  localparam [2:0] ST_WAITRS = 3'b100;
  localparam [2:0] ST_RLOAD  = 3'b101;
  localparam [2:0] ST_RDATA  = 3'b110;
  localparam [2:0] ST_IGNORE = 3'b111;
  // the ignore state swallows bits until stop, start, select high or a mode change

  // ============================================================
  // helpers
  // write registers are 8 or 16 bits wide depending on their sub-address
  function isWide;
    input [3:0] sub;
    reg [15:0] mask;
    begin
      mask   = `DMHP_WIDE_MASK;
      isWide = mask[sub];
    end
  endfunction

  function isReadSub;
    input [7:0] sub;
    begin
      isReadSub = (sub == `DMHP_SUB_RD_STAT) || (sub == `DMHP_SUB_RD_ADC);
    end
  endfunction

  // ============================================================
  // pin synchronisation
  // all four pins share one chain so their relative timing is kept
  wire [3:0] pinRaw = {protocolSelectPin,
                       selectLineN,
                       serialClockLine,
                       serialDataLineIn};
  wire [3:0] pinSync;
  wire [3:0] pinPrev;

  dmhp_sync #(
    .WIDTH       (4),
    .RESET_VALUE (`DMHP_SYNC_RESET)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .asyncIn  (pinRaw),
    .syncOut  (pinSync),
    .syncPrev (pinPrev)
  );

  // synchronised pin levels and their previous samples
  wire threeWire    = pinSync[3];
  wire threeWirePrv = pinPrev[3];
  wire selN         = pinSync[2];
  wire sclNow       = pinSync[1];
  wire sclPrv       = pinPrev[1];
  wire sdaNow       = pinSync[0];
  wire sdaPrv       = pinPrev[0];

  // ============================================================
  // bus conditions
  wire sclRise = sclNow & ~sclPrv;
  wire sclFall = ~sclNow & sclPrv;

  // in two-wire mode a data edge with the clock high on both samples is a bus condition
  wire startEv = ~threeWire & sclNow & sclPrv & sdaPrv & ~sdaNow;
  wire stopEv  = ~threeWire & sclNow & sclPrv & ~sdaPrv & sdaNow;
  // three-wire frame is off whenever select is high
  wire frameOff = threeWire & selN;
  // a mode change mid-transfer would leave the protocol ambiguous
  wire modeChange = threeWire ^ threeWirePrv;

  // ============================================================
  // state
  reg [2:0]  state_q;
  reg [3:0]  bitCnt_q;
  reg [7:0]  shift_q;
  // read byte, shifted left once per host clock fall
  reg [7:0]  txReg_q;
  reg [2:0]  txCnt_q;
  reg        ackPend_q;
  reg        ackOn_q;
  reg        sdaOe_q;
  // upper byte of a 16-bit register waits here for its lower byte
  reg        upperSeen_q;
  reg [7:0]  upperByte_q;
  reg [3:0]  wrAddr_q;
  reg [15:0] wrData_q;
  reg        wrStrobe_q;
  reg        rdSel_q;
  reg        rdStrobe_q;
  reg        active_q;

  wire [7:0] newByte = {shift_q[6:0], sdaNow};

  // ============================================================
  // byte framing
  // only these states shift host bits in on the clock rise
  wire       inByte  = (state_q == ST_ADDR) || (state_q == ST_SUB) || (state_q == ST_DATA);
  wire       ackSlot = (bitCnt_q == `DMHP_ACK_SLOT);
  wire       lastBit = (bitCnt_q == `DMHP_LAST_BIT);
  // the ninth clock only exists in two-wire mode
  wire [3:0] bitWrap = threeWire ? `DMHP_BIT_ZERO : `DMHP_ACK_SLOT;
  wire       addrHit = (newByte[7:1] == SLAVE_ADDR);
  wire       subWr   = (newByte <= `DMHP_SUB_WR_MAX);
  wire       txDone  = (txCnt_q == `DMHP_TX_LAST);

  // ============================================================
  // protocol engine
  always @(posedge clock) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      bitCnt_q    <= `DMHP_BIT_ZERO;
      shift_q     <= 8'h00;
      txReg_q     <= 8'h00;
      txCnt_q     <= `DMHP_TX_ZERO;
      ackPend_q   <= 1'b0;
      ackOn_q     <= 1'b0;
      sdaOe_q     <= 1'b0;
      upperSeen_q <= 1'b0;
      upperByte_q <= 8'h00;
      wrAddr_q    <= 4'h0;
      wrData_q    <= 16'h0000;
      wrStrobe_q  <= 1'b0;
      rdSel_q     <= 1'b0;
      rdStrobe_q  <= 1'b0;
      active_q    <= 1'b0;
    end else begin
      wrStrobe_q <= 1'b0;
      rdStrobe_q <= 1'b0;
      active_q   <= (state_q != ST_IDLE);
      // aborts outrank a start seen in the same sample
      if (modeChange || frameOff || stopEv) begin
        // drop everything and release the data pin
        state_q   <= ST_IDLE;
        bitCnt_q  <= `DMHP_BIT_ZERO;
        ackPend_q <= 1'b0;
        ackOn_q   <= 1'b0;
        sdaOe_q   <= 1'b0;
      end else if (startEv) begin
        // also serves as repeated start while waiting for the read address
        state_q     <= ST_ADDR;
        bitCnt_q    <= `DMHP_BIT_ZERO;
        ackPend_q   <= 1'b0;
        ackOn_q     <= 1'b0;
        sdaOe_q     <= 1'b0;
        upperSeen_q <= 1'b0;
      end else if (threeWire && (state_q == ST_IDLE)) begin
        // select is low here: the stream opens with the sub-address
        state_q     <= ST_SUB;
        bitCnt_q    <= `DMHP_BIT_ZERO;
        upperSeen_q <= 1'b0;
      end else if (sclRise) begin
        // bit and acknowledge steps wait for a host clock edge; start, stop and select act without one
        if (ackSlot) begin
          bitCnt_q <= `DMHP_BIT_ZERO;
        end else if (inByte) begin
          shift_q <= newByte;
          if (!lastBit) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else begin
            // two-wire inserts an acknowledge slot, three-wire does not
            bitCnt_q <= bitWrap;
            case (state_q)
              ST_ADDR: begin
                if (addrHit) begin
                  ackPend_q <= 1'b1;
                  state_q   <= newByte[0] ? ST_RLOAD : ST_SUB;
                end else begin
                  state_q <= ST_IGNORE;
                end
              end
              ST_SUB: begin
                if (subWr) begin
                  wrAddr_q  <= newByte[3:0];
                  ackPend_q <= ~threeWire;
                  state_q   <= ST_DATA;
                end else if (isReadSub(newByte)) begin
                  rdSel_q   <= newByte[0];
                  ackPend_q <= ~threeWire;
                  state_q   <= threeWire ? ST_RLOAD : ST_WAITRS;
                end else begin
                  // unknown sub-address is neither acknowledged nor used
                  state_q <= ST_IGNORE;
                end
              end
              ST_DATA: begin
                ackPend_q <= ~threeWire;
                if (isWide(wrAddr_q) && !upperSeen_q) begin
                  upperByte_q <= newByte;
                  upperSeen_q <= 1'b1;
                end else begin
                  wrData_q   <= upperSeen_q ? {upperByte_q, newByte} :
                                              {8'h00, newByte};
                  wrStrobe_q <= 1'b1;
                  // surplus bytes are refused until stop or select high
                  state_q    <= ST_IGNORE;
                end
              end
              default: begin
                state_q <= ST_IGNORE;
              end
            endcase
          end
        end
      end else if (sclFall) begin
        // the pin is only ever pulled low just after the clock falls; aborts and starts may release it at any time
        if (ackPend_q) begin
          sdaOe_q   <= 1'b1;
          ackOn_q   <= 1'b1;
          ackPend_q <= 1'b0;
        end else if (state_q == ST_RLOAD) begin
          // this edge also ends an acknowledge still being driven
          txReg_q    <= regRdData;
          sdaOe_q    <= ~regRdData[7];
          txCnt_q    <= `DMHP_TX_ZERO;
          rdStrobe_q <= 1'b1;
          ackOn_q    <= 1'b0;
          state_q    <= ST_RDATA;
        end else if (ackOn_q) begin
          sdaOe_q <= 1'b0;
          ackOn_q <= 1'b0;
        end else if (state_q == ST_RDATA) begin
          if (txDone) begin
            // host slot after the read byte is not examined
            sdaOe_q <= 1'b0;
            state_q <= ST_IGNORE;
          end else begin
            txReg_q <= {txReg_q[6:0], 1'b0};
            sdaOe_q <= ~txReg_q[6];
            txCnt_q <= txCnt_q + 3'h1;
          end
        end
      end
    end
  end

  // ============================================================
  // outputs
  // open drain: the pin is only pulled low, never driven high
  assign serialDataLineOut = 1'b0;
  assign serialDataLineOe  = sdaOe_q;
  assign regWrStrobe       = wrStrobe_q;
  assign regWrAddr         = wrAddr_q;
  assign regWrData         = wrData_q;
  assign regRdSel          = rdSel_q;
  assign regRdStrobe       = rdStrobe_q;
  assign busActive         = active_q;

endmodule

`default_nettype wire

//--- verilog/dmhp_consts.vh
// Purpose: shared constants of the dual mode serial host port
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef DMHP_CONSTS_VH
`define DMHP_CONSTS_VH

// ============================================================
// byte framing
`define DMHP_LAST_BIT     4'h7
`define DMHP_ACK_SLOT     4'h8
`define DMHP_BIT_ZERO     4'h0
`define DMHP_TX_LAST      3'h7
`define DMHP_TX_ZERO      3'h0

// ============================================================
// sub-address map
`define DMHP_SUB_WR_MAX   8'h0F
`define DMHP_SUB_RD_STAT  8'h80
`define DMHP_SUB_RD_ADC   8'h81
// one bit per write sub-address: set where the register is 16 bits wide
`define DMHP_WIDE_MASK    16'h80F7

// ============================================================
// synchroniser reset pattern {mode, select_n, clock, data}
`define DMHP_SYNC_RESET   4'h7

`endif

//--- verilog/dmhp_sync.v
// Purpose: two-flop synchroniser with one extra stage for edge detection
// Assumes: inputs are asynchronous pins
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none

module dmhp_sync #(
  parameter             WIDTH       = 4,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut,
  output wire [WIDTH-1:0] syncPrev
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;

  // ============================================================
  // resync chain
  always @(posedge clock) begin
    if (!rst_n) begin
      stage1_q <= RESET_VALUE;
      stage2_q <= RESET_VALUE;
      stage3_q <= RESET_VALUE;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  assign syncOut  = stage2_q;
  assign syncPrev = stage3_q;

endmodule

`default_nettype wire

//--- dv/dmhp_port_monitor.sv
// Purpose: port checker of the serial host port
// Assumes: bound to dmhp_serial_port
// Notes:   raw pins; windows cover sync lag
`timescale 1ns/10ps
`default_nettype none
module dmhp_port_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic protocolSelectPin,
  input wire logic selectLineN,
  input wire logic serialClockLine,
  input wire logic serialDataLineIn,
  input wire logic serialDataLineOut,
  input wire logic serialDataLineOe,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic busActive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========
  // events
  sequence s_start;
    !protocolSelectPin && serialClockLine && $fell(serialDataLineIn) ##1 serialClockLine[*2];
  endsequence
  sequence s_stop;
    !protocolSelectPin && serialClockLine && $rose(serialDataLineIn) ##1 serialClockLine[*2];
  endsequence
  property p_start;
    s_start |-> ##[1:6] busActive;
  endproperty
  property p_stop;
    s_stop |-> ##[1:6] !busActive;
  endproperty
  property p_drvLow;
    !serialDataLineOut && (!serialDataLineOe || busActive);
  endproperty
  property p_oeRise;
    $rose(serialDataLineOe) |-> !serialClockLine;
  endproperty
  property p_selIdle;
    protocolSelectPin && selectLineN [*6] |-> !serialDataLineOe;
  endproperty
  property p_wrPulse;
    regWrStrobe |=> !regWrStrobe;
  endproperty
  property p_wrScl;
    regWrStrobe |-> serialClockLine;
  endproperty
  property p_rdPulse;
    regRdStrobe |-> !serialClockLine ##1 !regRdStrobe;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_drvLow: assert property (p_drvLow) else $error("data driven high");
  a_oeRise: assert property (p_oeRise) else $error("data moved, clock high");
  a_selIdle: assert property (p_selIdle) else $error("drive while deselected");
  a_wrPulse: assert property (p_wrPulse) else $error("long write strobe");
  a_wrScl: assert property (p_wrScl) else $error("write off bit edge");
  a_rdPulse: assert property (p_rdPulse) else $error("bad read strobe");
endmodule
bind dmhp_serial_port dmhp_port_monitor u_mon (
  .clock(clock), .rst_n(rst_n), .protocolSelectPin(protocolSelectPin),
  .selectLineN(selectLineN), .serialClockLine(serialClockLine),
  .serialDataLineIn(serialDataLineIn), .serialDataLineOut(serialDataLineOut),
  .serialDataLineOe(serialDataLineOe), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .busActive(busActive));
`default_nettype wire

//--- dv/dmhp_host_model.sv
// Purpose: bus master driving the serial host port
// Assumes: data wire has a pull-up
// Notes:   link half period is 6 clocks
`timescale 1ns/10ps
`default_nettype none
module dmhp_host_model (
  input  wire logic clock,
  input  wire logic devOe,
  output var  logic scl,
  output var  logic selN,
  output var  logic mode,
  output wire logic sda
);
  logic hostLow;
  assign sda = !(hostLow || devOe);
  initial begin
    scl = 1'b1;
    selN = 1'b1;
    mode = 1'b0;
    hostLow = 1'b0;
  end
  task half;
    repeat (6) @(negedge clock);
  endtask
  task setMode(input logic m);
    mode = m;
    half();
  endtask
  task start;
    hostLow = 1'b0;
    half();
    scl = 1'b1;
    half();
    hostLow = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task stop;
    hostLow = 1'b1;
    half();
    scl = 1'b1;
    half();
    hostLow = 1'b0;
    half();
  endtask
  task open;
    scl = 1'b0;
    half();
    selN = 1'b0;
  endtask
  task close;
    half();
    selN = 1'b1;
    scl = 1'b1;
    half();
  endtask
  task xfer(input logic [7:0] d, input logic slot, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      hostLow = !d[i];
      half();
      scl = 1'b1;
      half();
      r[i] = sda;
      scl = 1'b0;
    end
    hostLow = 1'b0;
    ack = 1'b1;
    if (slot) begin
      half();
      scl = 1'b1;
      half();
      ack = !sda;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench of the serial host port
// Assumes: host model drives the bus pins
// Notes:   write rows first, then reads and refusals
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam logic [6:0] ADDR = 7'h5B; // arbitrary value
  logic        clock, rst_n, mode, selN, scl, sda, oe, wrS, rdSel, rdS, ok, rm, rw;
  logic [7:0]  regRdData, v;
  logic [6:0]  addrTx;
  logic [3:0]  wrA, rs;
  logic [15:0] wrD, rowD;
  int          error_cnt, check_count, wrCount, rdCount, n0;
  logic [21:0] rows [8] = '{{2'b00, 4'h3, 16'hFFA5}, {2'b01, 4'h0, 16'h1234},
    {2'b01, 4'hF, 16'h8001}, {2'b00, 4'h8, 16'h005A}, {2'b10, 4'hE, 16'h7E3C},
    {2'b11, 4'h1, 16'hC3A5}, {2'b10, 4'hD, 16'h0081}, {2'b11, 4'h7, 16'h00FF}};
  logic [7:0]  rdTab [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
  dmhp_serial_port #(.SLAVE_ADDR(ADDR)) dut (.clock(clock), .rst_n(rst_n),
    .protocolSelectPin(mode), .selectLineN(selN), .serialClockLine(scl),
    .serialDataLineIn(sda), .serialDataLineOut(), .serialDataLineOe(oe),
    .regWrStrobe(wrS), .regWrAddr(wrA), .regWrData(wrD), .regRdSel(rdSel),
    .regRdStrobe(rdS), .regRdData(regRdData), .busActive());
  dmhp_host_model host (.clock(clock), .devOe(oe), .scl(scl), .selN(selN),
    .mode(mode), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wrS) wrCount <= wrCount + 1;
    if (rdS) rdCount <= rdCount + 1;
  end
  task summarize;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // upper byte goes only for wide rows; lo=0 stops after it
  task wr(input logic m, input logic [7:0] s, input logic [15:0] d, input logic w,
          input logic lo);
    logic [7:0] r;
    logic a;
    ok = 1'b1;
    host.setMode(m);
    if (m) host.open();
    else begin
      host.start();
      host.xfer({addrTx, 1'b0}, 1'b1, r, a);
      ok &= a;
    end
    host.xfer(s, !m, r, a);
    ok &= a;
    if (w) host.xfer(d[15:8], !m, r, a);
    ok &= a;
    if (lo) host.xfer(d[7:0], !m, r, a);
    ok &= a;
    if (m) host.close();
    else host.stop();
  endtask
  task rd(input logic m, input logic [7:0] s);
    logic [7:0] r;
    logic a;
    ok = 1'b1;
    host.setMode(m);
    if (m) host.open();
    else begin
      host.start();
      host.xfer({ADDR, 1'b0}, 1'b1, r, a);
      ok &= a;
    end
    host.xfer(s, !m, r, a);
    ok &= a;
    if (!m) begin
      host.start();
      host.xfer({ADDR, 1'b1}, 1'b1, r, a);
      ok &= a;
    end
    host.xfer(8'hFF, !m, v, a);
    if (m) host.close();
    else host.stop();
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    regRdData = 8'h00;
    addrTx = ADDR;
    repeat (10) @(negedge clock);
    `CHK("oeRst", 1'b0, oe)
    `CHK("wrDRst", 16'h0000, wrD)
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      {rm, rw, rs, rowD} = rows[i];
      n0 = wrCount;
      wr(rm, {4'h0, rs}, rowD, rw, 1'b1);
      `CHK("ack", 1'b1, ok)
      `CHK("wrCnt", n0 + 1, wrCount)
      `CHK("wrA", rs, wrA)
      `CHK("wrD", rw ? rowD : {8'h00, rowD[7:0]}, wrD)
    end
    for (int i = 0; i < 4; i++) begin
      regRdData = rdTab[i];
      n0 = rdCount;
      rd(i >= 2, (i % 2 == 1) ? 8'h81 : 8'h80);
      `CHK("rdAck", 1'b1, ok)
      `CHK("rdV", rdTab[i], v)
      `CHK("rdSel", (i % 2 == 1), rdSel)
      `CHK("rdCnt", n0 + 1, rdCount)
    end
    n0 = wrCount;
    addrTx = ADDR ^ 7'h01;
    wr(1'b0, 8'h03, 16'h0011, 1'b0, 1'b1);
    `CHK("nackAddr", 1'b0, ok)
    addrTx = ADDR;
    wr(1'b0, 8'h10, 16'h0022, 1'b0, 1'b1);
    `CHK("nackSub", 1'b0, ok)
    wr(1'b0, 8'h00, 16'h3300, 1'b1, 1'b0);
    host.setMode(1'b1);
    host.xfer(8'h03, 1'b0, v, ok);
    host.xfer(8'h55, 1'b0, v, ok);
    `CHK("noWr", n0, wrCount)
    host.setMode(1'b0);
    summarize();
  end
endmodule
`default_nettype wire
